// ===== shared/flash_pe_map.vh
// Purpose: Constants for the flash program/erase control block
// Assumes: 32-bit AHB-Lite, one register per aligned word
// Notes:   Byte address of a register is four times its index
`ifndef FLASH_PE_MAP_VH
`define FLASH_PE_MAP_VH

// Register indices, compared against haddr[13:2]
`define IDX_CONTROL     12'hff8
`define IDX_SHARED      12'hff9
`define IDX_FREQ_HIGH   12'hffa
`define IDX_FREQ_LOW    12'hffb

// Control register command bytes
`define CMD_UNLOCK1     8'h73
`define CMD_UNLOCK2     8'h8c
`define CMD_PROT_SEL    8'h5e
`define CMD_PAGE_ERASE  8'h95
`define CMD_MASS_ERASE  8'h63

// Controller state codes
`define CODE_LOCKED     6'h00
`define CODE_FIRST      6'h01
`define CODE_SECOND     6'h02
`define CODE_UNLOCKED   6'h03
`define CODE_PROT_SEL   6'h04
`define CODE_PROG       6'h08
`define CODE_PAGE_ERASE 6'h10
`define CODE_MASS_ERASE 6'h20

// Field layout of the page select register
`define PS_INFO_BIT     7
`define PS_PAGE_MSB     6
`define PS_PAGE_LSB     0

// Reset values
`define RST_PAGE_SEL    8'h00
`define RST_GUARD       8'h00
`define RST_FREQ        16'h0000

// Program address mapping
`define PAGE_ADDR_MSB   15
`define PAGE_ADDR_LSB   9
`define INFO_BASE       16'hfe00

// Operation times in microseconds
`define PROG_TIME_US    16'd40
`define PERASE_TIME_US  16'd10000
`define MERASE_TIME_US  16'd20000

// Microseconds per millisecond, for the kHz based tick
`define US_PER_MS       17'd1000

`endif

// ===== rtl/us_tick_gen.v
// Purpose: One-cycle pulse per microsecond from a clock rate in kHz
// Assumes: Rate value stable while run is high
// Notes:   Fractional accumulator, so no rounding drift over long times
`timescale 1ns/100ps
`include "flash_pe_map.vh"
module us_tick_gen #(
   parameter FW = 16
) (
   input  wire          sysClk,
   input  wire          reset,
   input  wire          run,
   input  wire [FW-1:0] freqKhz,
   output reg           usTick
);
   reg  [FW:0] acc_r;
   wire [FW:0] sum = acc_r + `US_PER_MS;
   wire [FW:0] freqExt = {1'b0, freqKhz};

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         acc_r  <= {(FW+1){1'b0}};
         usTick <= 1'b0;
      end else if (!run || freqKhz == {FW{1'b0}}) begin
         // A zero rate would tick every cycle; hold instead
         acc_r  <= {(FW+1){1'b0}};
         usTick <= 1'b0;
      end else if (sum >= freqExt) begin
         acc_r  <= sum - freqExt;
         usTick <= 1'b1;
      end else begin
         acc_r  <= sum;
         usTick <= 1'b0;
      end
   end
endmodule

// ===== rtl/op_timer.v
// Purpose: Counts microsecond ticks up to a loaded target
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once in the cycle the target is reached
`timescale 1ns/100ps
module op_timer #(
   parameter W = 16
) (
   input  wire         sysClk,
   input  wire         reset,
   input  wire         start,
   input  wire         usTick,
   input  wire [W-1:0] target,
   output reg          busy,
   output reg          done
);
   reg [W-1:0] cnt_r;
   reg [W-1:0] tgt_r;

   always @(posedge sysClk or posedge reset) begin
      if (reset) begin
         cnt_r <= {W{1'b0}};
         tgt_r <= {W{1'b0}};
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_r <= {W{1'b0}};
            tgt_r <= target;
            busy  <= 1'b1;
         end else if (busy && usTick) begin
            if (cnt_r + 1'b1 >= tgt_r) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

// ===== rtl/flash_program_erase_control.v
// Purpose: Unlock, protect, page select and timing of flash
//          program and erase, reached over AHB-Lite
// Assumes: sys_clk 200 MHz; asynchronous reset stands for power-down
// Notes:   Operation length scales with the kHz rate software loads
//
// Function
// - The state code reads 000000 locked, 000001 after 73H, 000010 after 8CH, 000011 unlocked.
// - With the sector guard register selected the state code reads 000100.
// - During an operation the upper code bits read 001 program, 010 page erase, 100 mass erase.
// - Shared address writes load page select unless 5EH was written after 73H or while unlocked.
// - After 73H then 5EH only the next single shared write loads the sector guard register.
// - A page is 512 bytes and page erase covers addresses whose top seven bits match the page.
// - Page field bits 6 to 0 drive program address bits 15 to 9 for erase and page unlocking.
// - With info enable set the info area maps to FE00H through FFFFH of program space.
// - Eight guard bits clear at reset; each protects every 512-byte page whose address bits 11 to 9 equal its index.
// - A set guard bit cannot be cleared by writes, only by power-down.
`timescale 1ns/100ps
`include "flash_pe_map.vh"
module flash_program_erase_control #(
   parameter PROG_US   = 16'd40,
   parameter PERASE_US = 16'd10000,
   parameter MERASE_US = 16'd20000
) (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        progReq,
   input  wire [15:0] progAddr,
   input  wire [7:0]  progData,
   output reg         progRefused,
   output reg  [15:0] flashAddr,
   output reg  [7:0]  flashData,
   output reg         flashProgEn,
   output reg         flashPageEraseEn,
   output reg         flashMassEraseEn,
   output reg         infoAreaSel,
   output reg  [7:0]  sectorGuardOut,
   output reg  [5:0]  stateCodeOut
);
   // One-hot controller states
   localparam [7:0] S_LOCKED = 8'h01;
   localparam [7:0] S_FIRST  = 8'h02;
   localparam [7:0] S_SECOND = 8'h04;
   localparam [7:0] S_UNLOCK = 8'h08;
   localparam [7:0] S_PROT   = 8'h10;
   localparam [7:0] S_PROG   = 8'h20;
   localparam [7:0] S_PERASE = 8'h40;
   localparam [7:0] S_MERASE = 8'h80;
   localparam [15:0] RST_FREQ_W = `RST_FREQ;

   reg  [7:0]  state_r;
   reg  [7:0]  state_nxt;
   reg  [7:0]  pageSel_r;
   reg  [7:0]  sectorGuard_r;
   reg  [7:0]  freqHigh_r;
   reg  [7:0]  freqLow_r;
   reg         wrPend_r;
   reg  [11:0] wrIdx_r;
   reg  [5:0]  stateCode;
   reg  [31:0] readVal;
   reg  [15:0] opTarget;
   reg         opStart;
   reg         refuse;

   wire        addrPhase = hsel & htrans[1] & hready;
   wire [11:0] addrIdx   = haddr[13:2];
   wire        ctrlWr    = wrPend_r & (wrIdx_r == `IDX_CONTROL);
   wire        sharedWr  = wrPend_r & (wrIdx_r == `IDX_SHARED);
   wire [7:0]  wrByte    = hwdata[7:0];
   wire [15:0] clockKhz  = {freqHigh_r, freqLow_r};
   wire        usTick;
   wire        opBusy;
   wire        opDone;

   wire [6:0]  pageField =
      pageSel_r[`PS_PAGE_MSB:`PS_PAGE_LSB];
   wire [6:0]  reqPage   =
      progAddr[`PAGE_ADDR_MSB:`PAGE_ADDR_LSB];
   // Sector of a program address from bits 11 to 9, eight 512-byte sectors repeating every 4 KB
   wire [2:0]  reqSector = progAddr[11:9];
   wire [2:0]  pageSect  = pageField[2:0];
   wire        reqGuard  = sectorGuard_r[reqSector];
   wire        pageGuard = sectorGuard_r[pageSect];
   wire        infoHit   = pageSel_r[`PS_INFO_BIT] &
                           (progAddr >= `INFO_BASE);

   // Bus slave: address phase latched, writes land in the data phase
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrPend_r  <= 1'b0;
         wrIdx_r   <= 12'h000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            wrPend_r <= addrPhase & hwrite;
            wrIdx_r  <= addrIdx;
         end
         if (addrPhase && !hwrite) begin
            hrdata <= readVal;
         end
      end
   end

   // Read mux; unmapped words and upper bits read as zero
   always @* begin
      readVal = 32'h0000_0000;
      case (addrIdx)
         `IDX_CONTROL: begin
            readVal = {26'h0, stateCode};
         end
         `IDX_SHARED: begin
            if (state_r == S_PROT) begin
               readVal = {24'h0, sectorGuard_r};
            end else begin
               readVal = {24'h0, pageSel_r};
            end
         end
         `IDX_FREQ_HIGH: begin
            readVal = {24'h0, freqHigh_r};
         end
         `IDX_FREQ_LOW: begin
            readVal = {24'h0, freqLow_r};
         end
         default: begin
            readVal = 32'h0000_0000;
         end
      endcase
   end

   // State code from the one-hot state
   always @* begin
      case (state_r)
         S_LOCKED: stateCode = `CODE_LOCKED;
         S_FIRST:  stateCode = `CODE_FIRST;
         S_SECOND: stateCode = `CODE_SECOND;
         S_UNLOCK: stateCode = `CODE_UNLOCKED;
         S_PROT:   stateCode = `CODE_PROT_SEL;
         S_PROG:   stateCode = `CODE_PROG;
         S_PERASE: stateCode = `CODE_PAGE_ERASE;
         S_MERASE: stateCode = `CODE_MASS_ERASE;
         default:  stateCode = `CODE_LOCKED;
      endcase
   end

   // Sequencer next state
   always @* begin
      state_nxt = state_r;
      opStart   = 1'b0;
      opTarget  = PROG_US;
      refuse    = 1'b0;
      case (state_r)
         S_LOCKED: begin
            if (ctrlWr && wrByte == `CMD_UNLOCK1) begin
               state_nxt = S_FIRST;
            end
            refuse = progReq;
         end
         S_FIRST: begin
            refuse = progReq;
            if (ctrlWr) begin
               if (wrByte == `CMD_UNLOCK2) begin
                  state_nxt = S_SECOND;
               end else if (wrByte == `CMD_PROT_SEL) begin
                  state_nxt = S_PROT;
               end else begin
                  state_nxt = S_LOCKED;
               end
            end
         end
         S_SECOND: begin
            // Unlock completes one cycle after the second byte
            refuse = progReq;
            if (ctrlWr) begin
               state_nxt = S_LOCKED;
            end else begin
               state_nxt = S_UNLOCK;
            end
         end
         S_UNLOCK: begin
            if (ctrlWr) begin
               if (wrByte == `CMD_PROT_SEL) begin
                  state_nxt = S_PROT;
               end else if (wrByte == `CMD_PAGE_ERASE &&
                            !pageGuard) begin
                  state_nxt = S_PERASE;
                  opStart   = 1'b1;
                  opTarget  = PERASE_US;
               end else if (wrByte == `CMD_MASS_ERASE &&
                            sectorGuard_r == 8'h00) begin
                  state_nxt = S_MERASE;
                  opStart   = 1'b1;
                  opTarget  = MERASE_US;
               end else begin
                  state_nxt = S_LOCKED;
               end
               refuse = progReq;
            end else if (progReq) begin
               // Page unlocking: only the selected page, or the info area when enabled, programs
               if ((reqPage == pageField || infoHit) &&
                   !reqGuard) begin
                  state_nxt = S_PROG;
                  opStart   = 1'b1;
                  opTarget  = PROG_US;
               end else begin
                  refuse = 1'b1;
               end
            end
         end
         S_PROT: begin
            refuse = progReq;
            // One shared write is consumed, then the lock returns
            if (sharedWr || ctrlWr) begin
               state_nxt = S_LOCKED;
            end
         end
         S_PROG: begin
            refuse = progReq;
            if (opDone) begin
               state_nxt = S_UNLOCK;
            end
         end
         S_PERASE, S_MERASE: begin
            // Erase relocks so a stray erase cannot repeat
            refuse = progReq;
            if (opDone) begin
               state_nxt = S_LOCKED;
            end
         end
         default: begin
            state_nxt = S_LOCKED;
         end
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= S_LOCKED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Shared address: guard bits only ever set
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pageSel_r     <= `RST_PAGE_SEL;
         sectorGuard_r <= `RST_GUARD;
      end else if (sharedWr) begin
         if (state_r == S_PROT) begin
            sectorGuard_r <= sectorGuard_r | wrByte;
         end else begin
            pageSel_r <= wrByte;
         end
      end
   end

   // Clock rate in kHz, high byte and low byte
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         freqHigh_r <= RST_FREQ_W[15:8];
         freqLow_r  <= RST_FREQ_W[7:0];
      end else if (wrPend_r) begin
         if (wrIdx_r == `IDX_FREQ_HIGH) begin
            freqHigh_r <= wrByte;
         end
         if (wrIdx_r == `IDX_FREQ_LOW) begin
            freqLow_r <= wrByte;
         end
      end
   end

   us_tick_gen #(
      .FW      (16)
   ) uTick (
      .sysClk  (sys_clk),
      .reset   (reset),
      .run     (opBusy),
      .freqKhz (clockKhz),
      .usTick  (usTick)
   );

   op_timer #(
      .W       (16)
   ) uTimer (
      .sysClk  (sys_clk),
      .reset   (reset),
      .start   (opStart),
      .usTick  (usTick),
      .target  (opTarget),
      .busy    (opBusy),
      .done    (opDone)
   );

   // Array side outputs, all registered
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flashAddr        <= 16'h0000;
         flashData        <= 8'h00;
         flashProgEn      <= 1'b0;
         flashPageEraseEn <= 1'b0;
         flashMassEraseEn <= 1'b0;
         infoAreaSel      <= 1'b0;
         progRefused      <= 1'b0;
         sectorGuardOut   <= 8'h00;
         stateCodeOut     <= 6'h00;
      end else begin
         progRefused    <= refuse;
         sectorGuardOut <= sectorGuard_r;
         stateCodeOut   <= stateCode;
         infoAreaSel    <= pageSel_r[`PS_INFO_BIT];
         if (opStart && state_nxt == S_PROG) begin
            flashAddr <= progAddr;
            flashData <= progData;
         end else if (opStart) begin
            // Page base: top seven bits from the page field
            flashAddr <= {pageField, 9'h000};
            flashData <= 8'h00;
         end
         flashProgEn      <= state_nxt == S_PROG;
         flashPageEraseEn <= state_nxt == S_PERASE;
         flashMassEraseEn <= state_nxt == S_MERASE;
      end
   end
endmodule

// ===== test/flash_pe_sva.sv
// Purpose: Port assertions for the flash program/erase control
// Assumes: hready tied to hreadyout, hsel tied high
// Notes:   State code trails the sequencer by one cycle
`timescale 1ns/100ps
module flash_pe_sva (
   input logic        sys_clk,
   input logic        reset,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] hwdata,
   input logic        hready,
   input logic        progReq,
   input logic        progRefused,
   input logic [15:0] flashAddr,
   input logic        flashProgEn,
   input logic        flashPageEraseEn,
   input logic        flashMassEraseEn,
   input logic [7:0]  sectorGuardOut,
   input logic [5:0]  stateCodeOut
);
   logic       ctlPh_r, shPh_r, ctlD_r, shD_r;
   logic [7:0] page_r, guard_r, bD_r;
   wire        tk  = htrans[1] && hready && hwrite;
   wire [7:0]  b   = hwdata[7:0];
   wire [5:0]  st  = stateCodeOut;
   wire [2:0]  op  = {flashMassEraseEn, flashPageEraseEn, flashProgEn};
   wire        ctl = ctlPh_r && hready;
   wire        sh  = shPh_r && hready;
   // One cycle after a data phase, st shows the state that took the write
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctlPh_r <= 1'b0;
         shPh_r  <= 1'b0;
         ctlD_r  <= 1'b0;
         shD_r   <= 1'b0;
         bD_r    <= 8'h00;
         page_r  <= 8'h00;
         guard_r <= 8'h00;
      end else begin
         ctlPh_r <= tk && haddr[13:2] == 12'hff8;
         shPh_r  <= tk && haddr[13:2] == 12'hff9;
         ctlD_r  <= ctl;
         shD_r   <= sh;
         bD_r    <= b;
         // Mirror where a shared write lands, judged by the state it met
         if (shD_r && st == 6'h04)
            guard_r <= sectorGuardOut | bD_r;
         else if (shD_r)
            page_r <= bD_r;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_s1;
      ctlD_r && bD_r == 8'h73 && st == 6'h00 |-> ##1 st == 6'h01;
   endproperty
   a_s1: assert property (p_s1)
      else $error("first unlock step missing");
   property p_s2;
      ctlD_r && bD_r == 8'h8c && st == 6'h01 && !ctl |->
         ##1 st == 6'h02 ##1 st == 6'h03;
   endproperty
   a_s2: assert property (p_s2)
      else $error("second unlock step missing");
   property p_psel;
      ctlD_r && bD_r == 8'h5e && (st == 6'h01 || st == 6'h03) |->
         ##1 st == 6'h04;
   endproperty
   a_psel: assert property (p_psel)
      else $error("guard select code missing");
   property p_relock;
      ctlD_r && (st == 6'h02 || (st == 6'h01 && bD_r != 8'h8c &&
      bD_r != 8'h5e) || (st == 6'h03 && bD_r != 8'h5e && bD_r != 8'h95 &&
      bD_r != 8'h63)) |-> ##1 st == 6'h00;
   endproperty
   a_relock: assert property (p_relock)
      else $error("bad control byte did not relock");
   property p_sticky;
      (sectorGuardOut & $past(sectorGuardOut)) == $past(sectorGuardOut);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("guard bit cleared");
   property p_grd; shD_r && st == 6'h04 |-> ##1 sectorGuardOut == guard_r;
   endproperty
   a_grd: assert property (p_grd)
      else $error("guard write lost");
   // A later guard select may legally change the guard two cycles on
   property p_nogrd; shD_r && st != 6'h04 |-> ##1 $stable(sectorGuardOut);
   endproperty
   a_nogrd: assert property (p_nogrd)
      else $error("page write reached guard");
   property p_op; op != 3'b000 && $stable(op) |-> st[5:3] == op;
   endproperty
   a_op: assert property (p_op)
      else $error("operation code wrong");
   property p_ref;
      progReq && st == 6'h00 && $past(st) == 6'h00 |-> ##1 progRefused;
   endproperty
   a_ref: assert property (p_ref)
      else $error("locked program not refused");
   property p_ea;
      $rose(flashPageEraseEn) |-> flashAddr == {page_r[6:0], 9'h000};
   endproperty
   a_ea: assert property (p_ea)
      else $error("erase page address wrong");
endmodule

// ===== test/flash_array_model.sv
// Purpose: Behavioural flash array behind the control block
// Assumes: Each enable rises once per operation
// Notes:   Programming only clears bits, as real cells do
`timescale 1ns/100ps
module flash_array_model (
   input  logic        sys_clk,
   input  logic [15:0] flashAddr,
   input  logic [7:0]  flashData,
   input  logic        flashProgEn,
   input  logic        flashPageEraseEn,
   input  logic        flashMassEraseEn,
   input  logic [15:0] rdAddr,
   output logic [7:0]  rdData
);
   logic [7:0] mem [0:65535];
   logic [2:0] en_r = 3'b000;
   assign rdData = mem[rdAddr];
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(posedge sys_clk) begin
      en_r <= {flashMassEraseEn, flashPageEraseEn, flashProgEn};
      if (flashProgEn && !en_r[0])
         mem[flashAddr] <= mem[flashAddr] & flashData;
      if (flashPageEraseEn && !en_r[1])
         for (int i = 0; i < 512; i++)
            mem[{flashAddr[15:9], i[8:0]}] <= 8'hff;
      if (flashMassEraseEn && !en_r[2])
         foreach (mem[i]) mem[i] <= 8'hff;
   end
endmodule

// ===== test/flash_program_erase_control_test.sv
// Purpose: Self-checking bench for flash program/erase control
// Assumes: Short operation times; rate 2000 kHz ticks every 2nd cycle
// Notes:   Guard bits survive everything but reset
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
   miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(c) for (n = 0; n < 200 && !(c); n++) @(posedge sys_clk) #1; \
   if (!(c)) begin miscompares++; summarize(); end
module flash_program_erase_control_test;
   logic        sys_clk = 0, reset = 1, hwrite = 0, progReq = 0;
   logic [31:0] haddr = 0, hwdata = 0;
   logic [1:0]  htrans = 0;
   logic [15:0] progAddr = 0, rdAddr = 0;
   logic [7:0]  progData = 0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, progRefused, infoAreaSel;
   wire         flashProgEn, flashPageEraseEn, flashMassEraseEn;
   wire  [15:0] flashAddr;
   wire  [7:0]  flashData, sectorGuardOut, rdData;
   wire  [5:0]  stateCodeOut;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   flash_program_erase_control #(.PROG_US(16'd2), .PERASE_US(16'd3),
      .MERASE_US(16'd4)) uut (.sys_clk, .reset, .hsel(1'b1), .haddr,
      .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .progReq, .progAddr, .progData,
      .progRefused, .flashAddr, .flashData, .flashProgEn, .flashPageEraseEn,
      .flashMassEraseEn, .infoAreaSel, .sectorGuardOut, .stateCodeOut);
   flash_array_model arr (.sys_clk, .flashAddr, .flashData, .flashProgEn,
      .flashPageEraseEn, .flashMassEraseEn, .rdAddr, .rdData);
   always #2.5 sys_clk = ~sys_clk;
   task automatic bus(input logic w, input logic [11:0] i,
                      input logic [7:0] d, output logic [31:0] r);
      // Waits end only through the bench timeout
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {18'h0, i, 2'b00};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, i, d, r);
   endtask
   // Idle first: a read in the next address phase sees the old value
   task automatic rd(input logic [11:0] i, input logic [31:0] e);
      logic [31:0] r;
      @(posedge sys_clk);
      bus(1'b0, i, 8'h00, r);
      `CHK(r, e)
      `CHK({hreadyout, hresp}, 2'b10)
   endtask
   // Leading 00 relocks from any state but a running program or erase, so the sequence starts clean
   task automatic unl;
      wr(12'hff8, 8'h00);
      wr(12'hff8, 8'h73);
      wr(12'hff8, 8'h8c);
   endtask
   task automatic req(input logic [15:0] a, input logic e);
      @(posedge sys_clk);
      progReq  <= 1'b1;
      progAddr <= a;
      progData <= 8'($urandom);
      @(posedge sys_clk);
      progReq <= 1'b0;
      #1 `CHK(progRefused, e)
   endtask
   task automatic rate;
      wr(12'hffa, 8'h07);
      wr(12'hffb, 8'hd0);
   endtask
   // Erase base address of the page held in a page select value
   function automatic logic [15:0] page_base(input logic [7:0] ps);
      return {ps[6:0], 9'h000};
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      logic [7:0]  p, c;
      logic [15:0] a;
      int          n;
      void'($urandom(32'hb6cd));
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      `CHK(sectorGuardOut, 8'h00)
      rd(12'hff8, 32'h0);
      rd(12'hff9, 32'h0);
      rd(12'h123, 32'h0);
      repeat (4) begin
         p = $urandom;
         c = $urandom;
         if (c == 8'h8c || c == 8'h5e) c = 8'h11;
         wr(12'hff9, p);
         rd(12'hff9, {24'h0, p});
         `CHK(infoAreaSel, p[7])
         wr(12'hff8, 8'h73);
         rd(12'hff8, 32'h1);
         wr(12'hff8, c);
         rd(12'hff8, 32'h0);
      end
      wr(12'hff8, 8'h73);
      wr(12'hff8, 8'h5e);
      rd(12'hff8, 32'h4);
      wr(12'hff9, 8'h10);
      rd(12'hff9, {24'h0, p});
      `CHK(sectorGuardOut, 8'h10)
      wr(12'hff8, 8'h73);
      wr(12'hff8, 8'h5e);
      wr(12'hff9, 8'h00);
      rd(12'hff8, 32'h0);
      `CHK(sectorGuardOut, 8'h10)
      unl();
      wr(12'hff8, 8'h5e);
      rd(12'hff8, 32'h4);
      rd(12'hff9, 32'h10);
      wr(12'hff9, 8'h01);
      rd(12'hff9, {24'h0, p});
      `CHK(sectorGuardOut, 8'h11)
      rate();
      wr(12'hff9, 8'h82);
      unl();
      req(16'hfe10, 1'b0);
      `WAIT(!flashProgEn)
      wr(12'hff9, 8'h02);
      unl();
      a = {7'h02, 9'($urandom)};
      req(a, 1'b0);
      `CHK(flashProgEn, 1'b1)
      `CHK(flashAddr, a)
      `CHK(flashData, progData)
      @(posedge sys_clk) #1;
      `CHK(stateCodeOut[5:3], 3'b001)
      `WAIT(!flashProgEn)
      rdAddr = a;
      #1 `CHK(rdData, progData)
      rd(12'hff8, 32'h3);
      req({7'h03, 9'h000}, 1'b1);
      wr(12'hff9, 8'h04);
      unl();
      req({7'h04, 9'h000}, 1'b1);
      wr(12'hff8, 8'h00);
      rd(12'hff8, 32'h0);
      req(a, 1'b1);
      wr(12'hff9, 8'h02);
      unl();
      wr(12'hff8, 8'h95);
      `WAIT(flashPageEraseEn)
      `CHK(flashAddr, page_base(8'h02))
      @(posedge sys_clk) #1;
      `CHK(stateCodeOut[5:3], 3'b010)
      `WAIT(!flashPageEraseEn)
      #1 `CHK(rdData, 8'hff)
      rd(12'hff8, 32'h0);
      wr(12'hff9, 8'h00);
      unl();
      wr(12'hff8, 8'h95);
      rd(12'hff8, 32'h0);
      `CHK(flashPageEraseEn, 1'b0)
      unl();
      wr(12'hff8, 8'h63);
      rd(12'hff8, 32'h0);
      `CHK(flashMassEraseEn, 1'b0)
      // Reset stands in for power-down, the only way to drop guard bits
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(12'hff8, 32'h0);
      `CHK(sectorGuardOut, 8'h00)
      rate();
      unl();
      wr(12'hff8, 8'h63);
      `WAIT(flashMassEraseEn)
      @(posedge sys_clk) #1;
      `CHK(stateCodeOut[5:3], 3'b100)
      `WAIT(!flashMassEraseEn)
      rdAddr = 16'hfe10;
      #1 `CHK(rdData, 8'hff)
      summarize();
   end
endmodule
bind flash_program_erase_control flash_pe_sva chk (.sys_clk, .reset,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .progReq, .progRefused,
   .flashAddr, .flashProgEn, .flashPageEraseEn, .flashMassEraseEn,
   .sectorGuardOut, .stateCodeOut);
